// [common/phy_diag_regs.vh]
// Purpose: register offsets, field positions and reset values
// Assumes: 16-bit management registers, 5-bit register address
// Notes:   definitions only
`ifndef PHY_DIAG_REGS_VH
`define PHY_DIAG_REGS_VH

`define REG_BASIC_CONTROL   5'h00
`define REG_INT_CTRL_STAT   5'h1b
`define REG_CABLE_DIAG      5'h1d
`define REG_PHY_CONTROL_TWO 5'h1f

`define BC_SOFT_RESET       15
`define BC_LOOPBACK         14
`define BC_SPEED_100        13
`define BC_ANEG_ENABLE      12
`define BC_FULL_DUPLEX      8
`define BC_RESET_VALUE      16'h3100

`define IC_ENABLE_HI        15
`define IC_ENABLE_LO        8
`define IC_FLAG_HI          7
`define IC_FLAG_LO          0

`define CD_START            15
`define CD_RESULT_HI        14
`define CD_RESULT_LO        13
`define CD_COUNT_HI         8
`define CD_COUNT_LO         0
`define CD_RESULT_INVALID   2'h3
`define CD_RESULT_NORMAL    2'h0

`define P2_MDIX_SELECT      14
`define P2_AUTO_DISABLE     13
`define P2_INT_ACTIVE_HIGH  9
`define P2_TX_DISABLE       3
`define P2_REMOTE_LOOPBACK  2
`define P2_RESET_VALUE      16'h0000

`define MG_PREAMBLE_ONES    6'h20
`define MG_HEADER_LAST      6'h0b
`define MG_DATA_LAST        6'h0f
`define MG_OP_READ          2'h2
`define MG_OP_WRITE         2'h1
`define MG_BROADCAST_ADDR   5'h00

`endif

// [rtl/mgmt_serial.v]
// Purpose: serial management slave on the two-wire clock and data pins
// Assumes: management clock far slower than ref_clk
// Notes:   both pins pass two flip-flops before use
`timescale 1ns/1ps
`include "phy_diag_regs.vh"

module mgmt_serial #(
	parameter [4:0] PHY_ADDR = 5'h01
) (
	input  wire        ref_clk,
	input  wire        rst_b,
	input  wire        clk_en,
	input  wire        mdc,
	input  wire        mdio_in,
	output reg         mdio_out,
	output reg         mdio_oe,
	output reg  [4:0]  reg_addr,
	output reg  [15:0] wr_data,
	output reg         wr_stb,
	output reg         rd_stb,
	input  wire [15:0] rd_data
);
	localparam [2:0] S_PRE = 3'h0;
	localparam [2:0] S_ST  = 3'h1;
	localparam [2:0] S_HDR = 3'h2;
	localparam [2:0] S_TA  = 3'h3;
	localparam [2:0] S_TA2 = 3'h4;
	localparam [2:0] S_DAT = 3'h5;

	reg  [1:0]  mdc_sync;
	reg  [1:0]  dio_sync;
	reg         mdc_last;
	reg  [2:0]  state;
	reg  [5:0]  cnt;
	reg  [11:0] hdr;
	reg  [15:0] shreg;
	reg         is_read;
	reg         is_write;
	wire        rise = mdc_sync[1] & ~mdc_last;
	wire        bit_in = dio_sync[1];
	wire [11:0] hdr_full = {hdr[10:0], bit_in};
	wire        match = (hdr_full[9:5] == PHY_ADDR) || (hdr_full[9:5] == `MG_BROADCAST_ADDR);

	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			mdc_sync <= 2'h0;
			dio_sync <= 2'h0;
			mdc_last <= 1'b0;
			state    <= S_PRE;
			cnt      <= 6'h00;
			hdr      <= 12'h000;
			shreg    <= 16'h0000;
			is_read  <= 1'b0;
			is_write <= 1'b0;
			mdio_out <= 1'b0;
			mdio_oe  <= 1'b0;
			reg_addr <= 5'h00;
			wr_data  <= 16'h0000;
			wr_stb   <= 1'b0;
			rd_stb   <= 1'b0;
		end
		else if (clk_en)
		begin
			mdc_sync <= {mdc_sync[0], mdc};
			dio_sync <= {dio_sync[0], mdio_in};
			mdc_last <= mdc_sync[1];
			wr_stb   <= 1'b0;
			rd_stb   <= 1'b0;
			if (rise)
			begin
				case (state)
				S_PRE:
					if (bit_in)
						cnt <= (cnt == `MG_PREAMBLE_ONES) ? cnt : cnt + 6'h01;
					else if (cnt == `MG_PREAMBLE_ONES)
						state <= S_ST;
					else
						cnt <= 6'h00;
				S_ST:
				begin
					cnt   <= 6'h00;
					state <= bit_in ? S_HDR : S_PRE;
				end
				S_HDR:
				begin
					hdr <= hdr_full;
					cnt <= cnt + 6'h01;
					if (cnt == `MG_HEADER_LAST)
					begin
						reg_addr <= hdr_full[4:0];
						is_read  <= match && (hdr_full[11:10] == `MG_OP_READ);
						is_write <= match && (hdr_full[11:10] == `MG_OP_WRITE);
						state    <= S_TA;
					end
				end
				S_TA:
				begin
					if (is_read)
					begin
						rd_stb   <= 1'b1;
						shreg    <= rd_data;
						mdio_oe  <= 1'b1;
						mdio_out <= 1'b0;
					end
					state <= S_TA2;
				end
				S_TA2:
				begin
					if (is_read)
					begin
						mdio_out <= shreg[15];
						shreg    <= {shreg[14:0], 1'b0};
					end
					cnt   <= 6'h00;
					state <= S_DAT;
				end
				S_DAT:
				begin
					cnt <= cnt + 6'h01;
					if (is_read)
					begin
						mdio_out <= shreg[15];
						shreg    <= {shreg[14:0], 1'b0};
					end
					else
						shreg <= {shreg[14:0], bit_in};
					if (cnt == `MG_DATA_LAST)
					begin
						wr_stb   <= is_write;
						wr_data  <= {shreg[14:0], bit_in};
						mdio_oe  <= 1'b0;
						mdio_out <= 1'b0;
						cnt      <= 6'h00;
						state    <= S_PRE;
					end
				end
				default:
				begin
					cnt   <= 6'h00;
					state <= S_PRE;
				end
				endcase
			end
		end
	end
endmodule // mgmt_serial

// [rtl/phy_test_diag_irq_ctrl.v]
// Purpose: interrupt, crossover, loopback and cable diagnostic control
// Assumes: event and analog status inputs come from ref_clk logic
// Notes:   registers reached only through the serial management pins
`timescale 1ns/1ps
`include "phy_diag_regs.vh"

module phy_test_diag_irq_ctrl #(
	parameter [4:0]  PHY_ADDR     = 5'h01,
	parameter        REDUCED_PIN  = 0,
	parameter [15:0] QUIET_LIMIT  = 16'h1000,
	parameter [15:0] ECHO_LIMIT   = 16'h1000
) (
	input  wire       ref_clk,
	input  wire       rst_b,
	input  wire       clk_en,
	input  wire       mdc,
	input  wire       mdio_in,
	output wire       mdio_out,
	output wire       mdio_oe,
	input  wire [7:0] irq_event,
	output reg        interrupt_request_pin,
	input  wire       partner_swapped,
	output reg        mdix_select,
	input  wire       resolved_100,
	input  wire       resolved_full,
	output reg        speed_100,
	output reg        full_duplex,
	output reg        aneg_enable,
	output reg        local_loopback,
	output reg        remote_loopback,
	output reg        line_tx_enable,
	output reg        tdr_quiet_req,
	input  wire       partner_silent,
	output reg        tdr_fire,
	input  wire       tdr_done,
	input  wire [1:0] tdr_result,
	input  wire [8:0] tdr_count
);
	localparam [1:0] D_IDLE  = 2'h0;
	localparam [1:0] D_QUIET = 2'h1;
	localparam [1:0] D_FIRE  = 2'h2;
	localparam [1:0] D_WAIT  = 2'h3;

	wire [4:0]  reg_addr;
	wire [15:0] wr_data;
	wire        wr_stb;
	wire        rd_stb;
	reg  [15:0] rd_data;

	reg  [15:0] basic_control;
	reg  [7:0]  int_enable;
	reg  [7:0]  int_flags;
	reg  [15:0] phy_control_two;
	reg         diag_start;
	reg  [1:0]  diag_result;
	reg  [8:0]  diag_count;
	reg  [1:0]  diag_state;
	reg  [15:0] diag_timer;
	reg  [7:0]  next_flags;
	reg         int_active;

	wire wr_bc  = wr_stb && (reg_addr == `REG_BASIC_CONTROL);
	wire wr_ic  = wr_stb && (reg_addr == `REG_INT_CTRL_STAT);
	wire wr_cd  = wr_stb && (reg_addr == `REG_CABLE_DIAG);
	wire wr_p2  = wr_stb && (reg_addr == `REG_PHY_CONTROL_TWO);
	wire rd_ic  = rd_stb && (reg_addr == `REG_INT_CTRL_STAT);
	wire soft_reset = wr_bc && wr_data[`BC_SOFT_RESET];

	wire auto_xover = ~phy_control_two[`P2_AUTO_DISABLE];
	wire aneg_on = basic_control[`BC_ANEG_ENABLE];

	mgmt_serial #(
		.PHY_ADDR (PHY_ADDR)
	) u_mgmt (
		.ref_clk  (ref_clk),
		.rst_b    (rst_b),
		.clk_en   (clk_en),
		.mdc      (mdc),
		.mdio_in  (mdio_in),
		.mdio_out (mdio_out),
		.mdio_oe  (mdio_oe),
		.reg_addr (reg_addr),
		.wr_data  (wr_data),
		.wr_stb   (wr_stb),
		.rd_stb   (rd_stb),
		.rd_data  (rd_data)
	);

	// read mux, unmapped addresses read zero
	always @*
	begin
		rd_data = 16'h0000;
		case (reg_addr)
		`REG_BASIC_CONTROL:
			rd_data = basic_control;
		`REG_INT_CTRL_STAT:
			rd_data = {int_enable, int_flags};
		`REG_CABLE_DIAG:
		begin
			rd_data[`CD_START] = diag_start;
			rd_data[`CD_RESULT_HI:`CD_RESULT_LO] = diag_result;
			rd_data[`CD_COUNT_HI:`CD_COUNT_LO] = diag_count;
		end
		`REG_PHY_CONTROL_TWO:
			rd_data = phy_control_two;
		default:
			rd_data = 16'h0000;
		endcase
	end

	// a new event in the clearing cycle survives
	always @*
	begin
		next_flags = int_flags;
		if (rd_ic)
			next_flags = 8'h00;
		next_flags = next_flags | irq_event;
	end

	always @*
	begin
		int_active = |(int_flags & int_enable);
	end

	// management registers
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			basic_control   <= `BC_RESET_VALUE;
			int_enable      <= 8'h00;
			int_flags       <= 8'h00;
			phy_control_two <= `P2_RESET_VALUE;
		end
		else if (clk_en)
		begin
			int_flags <= next_flags;
			if (soft_reset)
			begin
				basic_control   <= `BC_RESET_VALUE;
				int_enable      <= 8'h00;
				int_flags       <= irq_event;
				phy_control_two <= `P2_RESET_VALUE;
			end
			else
			begin
				if (wr_bc)
					basic_control <= wr_data;
				if (wr_ic)
					int_enable <= wr_data[`IC_ENABLE_HI:`IC_ENABLE_LO];
				if (wr_p2)
					phy_control_two <= wr_data;
			end
		end
	end

	// pin and mode outputs, all registered
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			interrupt_request_pin <= 1'b1;
			mdix_select           <= 1'b0;
			speed_100             <= 1'b0;
			full_duplex           <= 1'b0;
			aneg_enable           <= 1'b1;
			local_loopback        <= 1'b0;
			remote_loopback       <= 1'b0;
			line_tx_enable        <= 1'b1;
		end
		else if (clk_en)
		begin
			interrupt_request_pin <= phy_control_two[`P2_INT_ACTIVE_HIGH] ? int_active : ~int_active;
			if (auto_xover)
				mdix_select <= partner_swapped;
			else
				mdix_select <= phy_control_two[`P2_MDIX_SELECT];
			aneg_enable <= aneg_on;
			speed_100   <= aneg_on ? resolved_100 : basic_control[`BC_SPEED_100];
			full_duplex <= aneg_on ? resolved_full : basic_control[`BC_FULL_DUPLEX];
			// forced full duplex only
			local_loopback <= basic_control[`BC_LOOPBACK] & ~aneg_on
				& basic_control[`BC_FULL_DUPLEX];
			// needs 100 full, forced or negotiated
			remote_loopback <= phy_control_two[`P2_REMOTE_LOOPBACK]
				& speed_100 & full_duplex;
			// reduced-pin variant keeps looped frames off the line
			line_tx_enable <= ~phy_control_two[`P2_TX_DISABLE]
				& ~(local_loopback & (REDUCED_PIN != 0));
		end
	end

	// cable diagnostic sequencer
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			diag_state    <= D_IDLE;
			diag_start    <= 1'b0;
			diag_result   <= `CD_RESULT_NORMAL;
			diag_count    <= 9'h000;
			diag_timer    <= 16'h0000;
			tdr_quiet_req <= 1'b0;
			tdr_fire      <= 1'b0;
		end
		else if (clk_en)
		begin
			tdr_fire <= 1'b0;
			case (diag_state)
			D_IDLE:
			begin
				tdr_quiet_req <= 1'b0;
				if (wr_cd && wr_data[`CD_START] && !soft_reset)
				begin
					diag_start    <= 1'b1;
					diag_timer    <= 16'h0000;
					tdr_quiet_req <= 1'b1;
					diag_state    <= D_QUIET;
				end
			end
			D_QUIET:
			begin
				diag_timer <= diag_timer + 16'h0001;
				if (partner_silent)
				begin
					tdr_fire   <= 1'b1;
					diag_timer <= 16'h0000;
					diag_state <= D_FIRE;
				end
				else if (diag_timer == QUIET_LIMIT)
				begin
					// partner never quiet: report invalid, no pulse
					diag_result   <= `CD_RESULT_INVALID;
					diag_count    <= 9'h000;
					diag_start    <= 1'b0;
					tdr_quiet_req <= 1'b0;
					diag_state    <= D_IDLE;
				end
			end
			D_FIRE:
				diag_state <= D_WAIT;
			D_WAIT:
			begin
				diag_timer <= diag_timer + 16'h0001;
				if (tdr_done)
				begin
					diag_result   <= tdr_result;
					diag_count    <= tdr_count;
					diag_start    <= 1'b0;
					tdr_quiet_req <= 1'b0;
					diag_state    <= D_IDLE;
				end
				else if (diag_timer == ECHO_LIMIT)
				begin
					diag_result   <= `CD_RESULT_INVALID;
					diag_count    <= 9'h000;
					diag_start    <= 1'b0;
					tdr_quiet_req <= 1'b0;
					diag_state    <= D_IDLE;
				end
			end
			default:
				diag_state <= D_IDLE;
			endcase
			if (soft_reset)
			begin
				diag_state    <= D_IDLE;
				diag_start    <= 1'b0;
				tdr_quiet_req <= 1'b0;
			end
		end
	end
endmodule // phy_test_diag_irq_ctrl

// [tb/phy_diag_chk.sv]
// Purpose: port checker for the diag control block
// Assumes: QUIET_LIMIT equals the bound instance
// Notes:   bound after the module
`timescale 1ns/1ps
module phy_diag_chk #(
	parameter [15:0] QUIET_LIMIT = 16'h1000
) (
	input logic ref_clk,
	input logic rst_b,
	input logic mdio_out,
	input logic mdio_oe,
	input logic interrupt_request_pin,
	input logic speed_100,
	input logic full_duplex,
	input logic aneg_enable,
	input logic local_loopback,
	input logic remote_loopback,
	input logic tdr_quiet_req,
	input logic partner_silent,
	input logic tdr_fire,
	input logic tdr_done
);
	reg [16:0] quiet_cnt;
	// cycles spent waiting for a silent partner
	always @(posedge ref_clk or negedge rst_b)
	begin
		if (!rst_b)
			quiet_cnt <= 17'h0_0000;
		else
			quiet_cnt <= (tdr_quiet_req && !partner_silent) ? quiet_cnt + 17'h0_0001 : 17'h0_0000;
	end
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	a_irq_idle_reset: assert property ($rose(rst_b) |-> interrupt_request_pin)
		else $error("interrupt pin active after reset");
	a_fire_single: assert property (tdr_fire |=> !tdr_fire)
		else $error("pulse longer than one cycle");
	a_fire_quiet: assert property (tdr_fire |-> tdr_quiet_req && $past(partner_silent))
		else $error("pulse without silent partner");
	a_quiet_bound: assert property (quiet_cnt <= {1'b0, QUIET_LIMIT} + 17'h0_0004)
		else $error("wait for silence not bounded");
	a_silent_fire: assert property ($rose(tdr_quiet_req) ##1 partner_silent |-> ##[0:8] tdr_fire)
		else $error("no pulse after silence");
	a_done_ends: assert property (tdr_quiet_req && tdr_done |-> ##[1:3] !tdr_quiet_req)
		else $error("test not ended by echo");
	a_ta_zero: assert property ($rose(mdio_oe) |-> !mdio_out)
		else $error("turnaround not driven low");
	a_loop_duplex: assert property ($rose(local_loopback) |-> full_duplex && !aneg_enable)
		else $error("local loop without forced full duplex");
	a_remote_100: assert property ($rose(remote_loopback) |-> speed_100 && full_duplex)
		else $error("remote loop outside 100 full");
endmodule // phy_diag_chk

bind phy_test_diag_irq_ctrl phy_diag_chk #(.QUIET_LIMIT(QUIET_LIMIT)) u_phy_diag_chk (.ref_clk, .rst_b,
	.mdio_out, .mdio_oe, .interrupt_request_pin, .speed_100, .full_duplex, .aneg_enable, .local_loopback,
	.remote_loopback, .tdr_quiet_req, .partner_silent, .tdr_fire, .tdr_done);

// [tb/mgmt_master.sv]
// Purpose: management controller model on the two-wire pins
// Assumes: unit address 1, clock 5 MHz
// Notes:   clock stands low between frames
`timescale 1ns/1ps
module mgmt_master (
	output reg  mdc,
	output reg  m_oe,
	output reg  m_out,
	input  wire mdio
);
	initial
	begin
		mdc = 1'b0;
		m_oe = 1'b0;
		m_out = 1'b1;
	end
	// read data is taken just before each rise
	task automatic xfer(
		input  logic        rd,
		input  logic [4:0]  ra,
		input  logic [15:0] wd,
		output logic [15:0] q
	);
		logic [63:0] f;
		integer      i;
		begin
			f = {32'hffff_ffff, 2'b01, rd ? 2'b10 : 2'b01, 5'h01, ra, 2'b10, wd};
			for (i = 63; i >= 0; i = i - 1)
			begin
				m_out = f[i];
				m_oe = !rd || i > 17;
				#100;
				if (i < 16)
					q[i] = mdio;
				mdc = 1'b1;
				#100;
				mdc = 1'b0;
			end
			m_oe = 1'b0;
			#400;
		end
	endtask
endmodule // mgmt_master

// [tb/phy_test_diag_irq_ctrl_tb.sv]
// Purpose: self-checking bench for the diag control block
// Assumes: short diagnostic limits
// Notes:   status bits packed into st
`timescale 1ns/1ps
module phy_test_diag_irq_ctrl_tb;
	logic       ref_clk = 1'b0;
	logic       rst_b = 1'b0;
	logic       clk_en = 1'b1;
	logic [7:0] irq_event = 8'h00;
	logic       partner_swapped = 1'b0;
	logic       resolved_100 = 1'b1;
	logic       resolved_full = 1'b0;
	logic       partner_silent = 1'b1;
	logic       tdr_done = 1'b0;
	logic [1:0] tdr_result = 2'h0;
	logic [8:0] tdr_count = 9'h000;
	integer     num_errors = 0;
	integer     n_compared = 0;
	integer     n_fire = 0;
	wire        mdc, m_oe, m_out, mdio, mdio_out, mdio_oe, interrupt_request_pin, mdix_select;
	wire        speed_100, full_duplex, aneg_enable, local_loopback, remote_loopback;
	wire        line_tx_enable, tdr_quiet_req, tdr_fire;
	wire [15:0] st = {8'h00, mdix_select, interrupt_request_pin, local_loopback, remote_loopback,
		speed_100, full_duplex, aneg_enable, line_tx_enable};
	// pull-up when nobody drives
	assign mdio = mdio_oe ? mdio_out : (m_oe ? m_out : 1'b1);
	always #10 ref_clk = ~ref_clk;
	phy_test_diag_irq_ctrl #(.QUIET_LIMIT(16'h0010), .ECHO_LIMIT(16'h0010)) u_phy_test_diag_irq_ctrl (
		.ref_clk, .rst_b, .clk_en, .mdc, .mdio_in(mdio), .mdio_out, .mdio_oe, .irq_event,
		.interrupt_request_pin, .partner_swapped, .mdix_select, .resolved_100, .resolved_full, .speed_100,
		.full_duplex, .aneg_enable, .local_loopback, .remote_loopback, .line_tx_enable, .tdr_quiet_req,
		.partner_silent, .tdr_fire, .tdr_done, .tdr_result, .tdr_count);
	mgmt_master u_mgmt_master (.mdc, .m_oe, .m_out, .mdio);
	// echo one cycle after each pulse
	always @(negedge ref_clk)
	begin
		if (tdr_fire === 1'b1)
		begin
			n_fire = n_fire + 1;
			@(posedge ref_clk) #1 tdr_done = 1'b1;
			@(posedge ref_clk) #1 tdr_done = 1'b0;
		end
	end
	task automatic tick;
		begin
			@(posedge ref_clk);
			#1;
		end
	endtask
	task automatic close_out;
		begin
			$display("errors %0d compared %0d", num_errors, n_compared);
			if (num_errors == 0 && n_compared > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp)
			begin
				num_errors = num_errors + 1;
				$display("[ERR] %0t got %h expected %h", $time, got, exp);
			end
		end
	endtask
	task automatic wr(input logic [4:0] ra, input logic [15:0] d);
		logic [15:0] q;
		begin
			tick;
			u_mgmt_master.xfer(1'b0, ra, d, q);
		end
	endtask
	task automatic rdc(input logic [4:0] ra, input logic [15:0] exp);
		logic [15:0] q;
		begin
			tick;
			u_mgmt_master.xfer(1'b1, ra, 16'h0000, q);
			chk(q, exp);
		end
	endtask
	task automatic pulse(input logic [7:0] v);
		begin
			tick;
			irq_event = v;
			tick;
			irq_event = 8'h00;
			repeat (3) tick;
		end
	endtask
	task automatic t_irq;
		begin
			wr(5'h1b, 16'h0400);
			pulse(8'h01);
			chk(st, 16'h004b);
			pulse(8'h04);
			chk(st, 16'h000b);
			rdc(5'h1b, 16'h0405);
			chk(st, 16'h004b);
			rdc(5'h1b, 16'h0400);
			wr(5'h1f, 16'h0200);
			chk(st, 16'h000b);
			pulse(8'h04);
			chk(st, 16'h004b);
			rdc(5'h1b, 16'h0404);
			chk(st, 16'h000b);
			wr(5'h1f, 16'h0000);
			// event while frozen must not latch
			clk_en = 1'b0;
			pulse(8'h04);
			clk_en = 1'b1;
			tick;
			chk(st, 16'h004b);
			rdc(5'h1b, 16'h0400);
		end
	endtask
	task automatic t_mdix;
		begin
			partner_swapped = 1'b1;
			repeat (4) tick;
			chk(st, 16'h00cb);
			wr(5'h1f, 16'h2000);
			chk(st, 16'h004b);
			wr(5'h1f, 16'h6000);
			partner_swapped = 1'b0;
			repeat (4) tick;
			chk(st, 16'h00cb);
			wr(5'h1f, 16'h0000);
			chk(st, 16'h004b);
		end
	endtask
	task automatic t_loop;
		begin
			wr(5'h00, 16'h4100);
			chk(st, 16'h0065);
			wr(5'h00, 16'h6100);
			chk(st, 16'h006d);
			wr(5'h1f, 16'h0008);
			chk(st, 16'h006c);
			wr(5'h1f, 16'h0000);
			chk(st, 16'h006d);
			wr(5'h00, 16'h6000);
			chk(st, 16'h0049);
			wr(5'h00, 16'h2100);
			wr(5'h1f, 16'h0004);
			chk(st, 16'h005d);
			wr(5'h00, 16'h0100);
			chk(st, 16'h0045);
			wr(5'h00, 16'h8000);
			rdc(5'h1f, 16'h0000);
			rdc(5'h00, 16'h3100);
			chk(st, 16'h004b);
			// negotiated 100 full also allows remote loop
			resolved_full = 1'b1;
			wr(5'h1f, 16'h0004);
			chk(st, 16'h005f);
			wr(5'h1f, 16'h0000);
			resolved_full = 1'b0;
		end
	endtask
	task automatic diag(input logic s, input logic [15:0] exp, input integer fires);
		integer      k;
		logic [15:0] q;
		begin
			tick;
			partner_silent = s;
			wr(5'h1d, 16'h8000);
			q = 16'h8000;
			for (k = 0; k < 5 && q[15] !== 1'b0; k = k + 1)
				u_mgmt_master.xfer(1'b1, 5'h1d, 16'h0000, q);
			if (q[15] !== 1'b0)
			begin
				num_errors = num_errors + 1;
				$display("[ERR] %0t start bit never cleared", $time);
				close_out;
			end
			chk(q, exp);
			chk(n_fire[15:0], fires[15:0]);
		end
	endtask
	task automatic t_diag;
		integer c;
		begin
			wr(5'h1f, 16'h2000);
			for (c = 0; c < 3; c = c + 1)
			begin
				tdr_result = c[1:0];
				tdr_count = 9'h1ff - c[8:0];
				diag(1'b1, {1'b0, c[1:0], 4'h0, 9'h1ff - c[8:0]}, c + 1);
			end
			diag(1'b0, 16'h6000, 3);
		end
	endtask
	initial
	begin
		repeat (3) @(posedge ref_clk);
		#1 rst_b = 1'b1;
		tick;
		chk(st, 16'h004b);
		rdc(5'h00, 16'h3100);
		rdc(5'h1f, 16'h0000);
		rdc(5'h05, 16'h0000);
		t_irq;
		t_mdix;
		t_loop;
		t_diag;
		close_out;
	end
endmodule // phy_test_diag_irq_ctrl_tb
